// [design/lhfs_cfg.svh]
`ifndef LHFS_CFG_SVH
`define LHFS_CFG_SVH
`define LHFS_OFF_FUNSEL 12'h030
`define LHFS_OFF_LINCTL 12'h034
`define LHFS_RST_FUNSEL 32'h0000_0000
`define LHFS_RST_LINCTL 32'h000C_0000
`define LHFS_POS_PID 24
`define LHFS_POS_HEADSEL 22
`define LHFS_POS_DELIM 20
`define LHFS_POS_BRK 16
`define LHFS_POS_IDPEN 9
`define LHFS_POS_SHD 8
`define LHFS_POS_MUTE 4
`define LHFS_POS_SLAVE 0
`endif

// [design/lhfs_pkg.sv]
package lhfs_pkg;
    typedef enum logic [1:0] {
        LHFS_FN_UART = 2'b00,
        LHFS_FN_LIN = 2'b01,
        LHFS_FN_IR = 2'b10,
        LHFS_FN_RS485 = 2'b11
    } lhfs_func_t;
    typedef enum logic [1:0] {
        LHFS_HD_BREAK = 2'b00,
        LHFS_HD_SYNC = 2'b01,
        LHFS_HD_ID = 2'b10,
        LHFS_HD_RSVD = 2'b11
    } lhfs_head_t;
    typedef struct packed {
        logic [7:0] pid;
        logic [1:0] headSel;
        logic [1:0] delimLen;
        logic [3:0] breakCount;
        logic idParityEn;
        logic sendHeader;
        logic muteEn;
        logic slaveEn;
    } lhfs_linctl_t;
    typedef struct packed {
        logic sendBreak;
        logic sendSync;
        logic sendId;
        logic [4:0] breakBits;
        logic [2:0] delimBits;
        logic [7:0] txId;
    } lhfs_hdr_t;
endpackage

// [design/lhfs_pid_parity.sv]
`timescale 1ns/100ps
module lhfs_pid_parity
    import lhfs_pkg::*;
(
    input wire logic [7:0] pidIn,
    input wire logic parityEn,
    output logic [7:0] pidOut
);
    logic p0;
    logic p1;
    always_comb begin
        p0 = pidIn[0] ^ pidIn[1] ^ pidIn[2] ^ pidIn[4];
        p1 = ~(pidIn[1] ^ pidIn[3] ^ pidIn[4] ^ pidIn[5]);
        // Software supplies parity itself when disabled
        pidOut = parityEn ? {p1, p0, pidIn[5:0]} : pidIn;
    end
endmodule

// [design/lhfs_lin_header_select.sv]
`timescale 1ns/100ps
`include "lhfs_cfg.svh"
module lhfs_lin_header_select
    import lhfs_pkg::*;
#(
    parameter int PORT_INDEX = 0
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic headerDone,
    output lhfs_func_t function_selector,
    output lhfs_linctl_t linControl,
    output lhfs_hdr_t headerPlan,
    output logic headerStart,
    output logic unmuteOnBreak,
    output logic unmuteOnSync,
    output logic unmuteOnId
);
    localparam bit LIN_OK = (PORT_INDEX < 3);
    localparam bit RS485_OK = (PORT_INDEX < 2);

    logic rstSync1;
    logic rstSync2;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rstSync1 <= 1'b0;
            rstSync2 <= 1'b0;
        end else begin
            rstSync1 <= 1'b1;
            rstSync2 <= rstSync1;
        end
    end

    lhfs_func_t funcSel;
    lhfs_func_t next_funcSel;
    lhfs_linctl_t ctl;
    lhfs_linctl_t next_ctl;
    logic [31:0] ctlWord;
    logic [31:0] next_prdata;
    logic [7:0] pidParity;
    logic wrAccess;
    logic rdAccess;
    logic hitFun;
    logic hitCtl;
    logic [31:0] strbMask;
    lhfs_hdr_t next_headerPlan;
    logic next_headerStart;

    assign pready = 1'b1;
    assign wrAccess = psel && penable && pwrite;
    assign rdAccess = psel && !penable && !pwrite;
    assign hitFun = (paddr == `LHFS_OFF_FUNSEL);
    assign hitCtl = (paddr == `LHFS_OFF_LINCTL);
    assign pslverr = psel && penable && !hitFun && !hitCtl;

    lhfs_pid_parity parity (
        .pidIn(ctl.pid),
        .parityEn(ctl.idParityEn),
        .pidOut(pidParity)
    );

    always_comb begin
        for (int i = 0; i < 4; i++) begin
            strbMask[i*8 +: 8] = {8{pstrb[i]}};
        end
    end

    function automatic logic [31:0] pack_ctl(input lhfs_linctl_t c);
        logic [31:0] w;
        w = 32'h0000_0000;
        w[`LHFS_POS_PID +: 8] = c.pid;
        w[`LHFS_POS_HEADSEL +: 2] = c.headSel;
        w[`LHFS_POS_DELIM +: 2] = c.delimLen;
        w[`LHFS_POS_BRK +: 4] = c.breakCount;
        w[`LHFS_POS_IDPEN] = c.idParityEn;
        w[`LHFS_POS_SHD] = c.sendHeader;
        w[`LHFS_POS_MUTE] = c.muteEn;
        w[`LHFS_POS_SLAVE] = c.slaveEn;
        return w;
    endfunction

    always_comb begin
        next_funcSel = funcSel;
        next_ctl = ctl;
        next_prdata = prdata;
        ctlWord = (pack_ctl(ctl) & ~strbMask) | (pwdata & strbMask);
        if (wrAccess && hitFun && pstrb[0]) begin
            // Unsupported codes on this port are dropped, keeping the old mode
            unique case (lhfs_func_t'(pwdata[1:0]))
                LHFS_FN_UART, LHFS_FN_IR: next_funcSel = lhfs_func_t'(pwdata[1:0]);
                LHFS_FN_LIN: if (LIN_OK) next_funcSel = LHFS_FN_LIN;
                LHFS_FN_RS485: if (RS485_OK) next_funcSel = LHFS_FN_RS485;
            endcase
        end
        if (wrAccess && hitCtl && LIN_OK) begin
            next_ctl.pid = ctlWord[`LHFS_POS_PID +: 8];
            next_ctl.headSel = ctlWord[`LHFS_POS_HEADSEL +: 2];
            next_ctl.delimLen = ctlWord[`LHFS_POS_DELIM +: 2];
            next_ctl.breakCount = ctlWord[`LHFS_POS_BRK +: 4];
            next_ctl.idParityEn = ctlWord[`LHFS_POS_IDPEN];
            next_ctl.sendHeader = ctlWord[`LHFS_POS_SHD];
            next_ctl.muteEn = ctlWord[`LHFS_POS_MUTE];
            next_ctl.slaveEn = ctlWord[`LHFS_POS_SLAVE];
        end else if (headerDone) begin
            // Send request self-clears when the line side finishes
            next_ctl.sendHeader = 1'b0;
        end
        if (rdAccess) begin
            if (hitFun) begin
                next_prdata = {30'h0000_0000, funcSel};
            end else if (hitCtl) begin
                next_prdata = pack_ctl(ctl);
                next_prdata[`LHFS_POS_PID +: 8] = pidParity;
            end else begin
                next_prdata = 32'h0000_0000;
            end
        end
    end

    always_comb begin
        next_headerPlan.sendBreak = 1'b1;
        next_headerPlan.sendSync = (ctl.headSel == LHFS_HD_SYNC)
            || (ctl.headSel == LHFS_HD_ID);
        next_headerPlan.sendId = (ctl.headSel == LHFS_HD_ID);
        next_headerPlan.breakBits = {1'b0, ctl.breakCount} + 5'h01;
        next_headerPlan.delimBits = {1'b0, ctl.delimLen} + 3'h1;
        next_headerPlan.txId = pidParity;
        // One pulse per send request, master LIN only
        next_headerStart = wrAccess && hitCtl && LIN_OK && pwdata[`LHFS_POS_SHD]
            && pstrb[1] && !ctl.sendHeader && !ctlWord[`LHFS_POS_SLAVE]
            && (funcSel == LHFS_FN_LIN);
    end

    always_ff @(posedge sys_clk or negedge rstSync2) begin
        if (!rstSync2) begin
            funcSel <= LHFS_FN_UART;
            ctl <= '{pid: 8'h00, headSel: 2'h0, delimLen: 2'h0,
                breakCount: 4'(`LHFS_RST_LINCTL >> `LHFS_POS_BRK),
                idParityEn: 1'b0, sendHeader: 1'b0, muteEn: 1'b0,
                slaveEn: 1'b0};
            prdata <= 32'h0000_0000;
            headerPlan <= '0;
            headerStart <= 1'b0;
        end else begin
            funcSel <= next_funcSel;
            ctl <= next_ctl;
            prdata <= next_prdata;
            headerPlan <= next_headerPlan;
            headerStart <= next_headerStart;
        end
    end

    always_comb begin
        function_selector = funcSel;
        linControl = ctl;
        linControl.pid = pidParity;
        // Slave leaves mute after the portion the header select names
        unmuteOnBreak = ctl.slaveEn && ctl.muteEn && ctl.headSel == LHFS_HD_BREAK;
        unmuteOnSync = ctl.slaveEn && ctl.muteEn && ctl.headSel == LHFS_HD_SYNC;
        unmuteOnId = ctl.slaveEn && ctl.muteEn && ctl.headSel == LHFS_HD_ID;
    end
endmodule

// [testbench/lhfs_sva.sv]
`timescale 1ns/100ps
`include "lhfs_cfg.svh"
module lhfs_sva
    import lhfs_pkg::*;
#(
    parameter int PORT_INDEX = 0
) (
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    input wire logic pslverr,
    input wire logic headerStart,
    input wire lhfs_func_t function_selector,
    input wire lhfs_linctl_t linControl,
    input wire lhfs_hdr_t headerPlan
);
    logic [2:0] up;
    logic [2:0] next_up;
    logic wr;
    lhfs_linctl_t c;
    lhfs_hdr_t h;
    assign c = linControl;
    assign h = headerPlan;
    assign wr = psel && penable && pwrite;
    // Plan lags the registers by one cycle, so skip the first edges after reset
    always_comb next_up = up[2] ? up : up + 3'd1;
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) up <= 3'd0;
        else up <= next_up;
    end
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    property p_rst; up == 3'd1 |-> c == 20'h0_00C0 && function_selector == LHFS_FN_UART; endproperty
    a_rst: assert property (p_rst) else $error("reset value");
    property p_brk; up[2] |-> h.breakBits == 5'($past(c.breakCount)) + 5'd1; endproperty
    a_brk: assert property (p_brk) else $error("break length");
    property p_dlm; up[2] |-> h.delimBits == 3'($past(c.delimLen)) + 3'd1; endproperty
    a_dlm: assert property (p_dlm) else $error("delimiter length");
    property p_hdr; up[2] |-> h.sendSync == ($past(c.headSel) inside {2'b01, 2'b10})
        && h.sendId == ($past(c.headSel) == 2'b10); endproperty
    a_hdr: assert property (p_hdr) else $error("header fields");
    property p_sta; headerStart |-> $past(wr && paddr == `LHFS_OFF_LINCTL && pwdata[8]); endproperty
    a_sta: assert property (p_sta) else $error("start cause");
    property p_one; headerStart |=> !headerStart; endproperty
    a_one: assert property (p_one) else $error("start width");
    property p_par; c.idParityEn |-> c.pid[7:6] ==
        {~(c.pid[1] ^ c.pid[3] ^ c.pid[4] ^ c.pid[5]), c.pid[0] ^ c.pid[1] ^ c.pid[2] ^ c.pid[4]};
    endproperty
    a_par: assert property (p_par) else $error("parity");
    property p_fn; wr && paddr == `LHFS_OFF_FUNSEL && pstrb[0] && PORT_INDEX < 2
        |=> function_selector == $past(pwdata[1:0]); endproperty
    a_fn: assert property (p_fn) else $error("function select");
    c_hs: cover property (headerStart);
    c_par: cover property (c.idParityEn);
    c_err: cover property (pslverr);
endmodule
bind lhfs_lin_header_select lhfs_sva #(.PORT_INDEX(PORT_INDEX)) u_sva (.*);

// [testbench/lhfs_lin_node.sv]
`timescale 1ns/100ps
module lhfs_lin_node
    import lhfs_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rstn,
    input wire logic [3:0] bitCycles,
    input wire logic headerStart,
    input wire lhfs_hdr_t headerPlan,
    output logic headerDone
);
    int left;
    logic go;
    // Plan settles one cycle after the start pulse
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            left <= 0;
            go <= 1'b0;
            headerDone <= 1'b0;
        end else begin
            go <= headerStart;
            headerDone <= left == 1;
            if (go) left <= bitCycles * (headerPlan.breakBits + headerPlan.delimBits
                + (headerPlan.sendSync ? 10 : 0) + (headerPlan.sendId ? 10 : 0));
            else if (left > 0) left <= left - 1;
        end
    end
endmodule

// [testbench/lin_header_function_select_tb_top.sv]
`timescale 1ns/100ps
module lin_header_function_select_tb_top;
    import lhfs_pkg::*;
    logic sys_clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 0;
    logic [31:0] pwdata = 0, prdata, rnd = 32'd14220, v;
    logic [3:0] pstrb = 4'hF, bitCycles = 1;
    logic pready, pslverr, headerDone, headerStart, unmuteOnBreak, unmuteOnSync, unmuteOnId;
    lhfs_func_t function_selector;
    lhfs_linctl_t linControl;
    lhfs_hdr_t headerPlan;
    logic [32:0] expq[$];
    int errors = 0, checks_done = 0, cyc = 0;
    always #50 sys_clk = ~sys_clk;
    lhfs_lin_header_select dut (.*);
    lhfs_lin_node node (.*);
    function automatic logic [31:0] xs();
        rnd ^= rnd << 13;
        rnd ^= rnd >> 17;
        rnd ^= rnd << 5;
        return rnd;
    endfunction
    function automatic logic [7:0] pidp(input logic [5:0] i);
        return {~(i[1] ^ i[3] ^ i[4] ^ i[5]), i[0] ^ i[1] ^ i[2] ^ i[4], i};
    endfunction
    task automatic check(input logic [32:0] seen, input logic [32:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("mismatch t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk) penable <= 1;
        do @(posedge sys_clk); while (pready !== 1'b1);
        psel <= 0;
        penable <= 0;
        // Idle edge so a following call never reassigns psel in this time step
        @(posedge sys_clk);
    endtask
    task automatic rd(input logic [11:0] a, input logic [32:0] e);
        expq.push_back(e);
        apb(0, a, 32'h0);
    endtask
    task automatic conclude();
        $display("errors=%0d checks_done=%0d", errors, checks_done);
        if (errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask
    // Read data is taken only at the edge that completes the access
    always @(posedge sys_clk) begin
        if (psel && penable && pready === 1'b1 && !pwrite) check({pslverr, prdata}, expq.pop_front());
        if (++cyc > 5000) begin
            errors++;
            conclude();
        end
    end
    initial begin
        repeat (5) @(posedge sys_clk);
        rstn <= 1;
        repeat (4) @(posedge sys_clk);
        rd(12'h030, 33'h0);
        rd(12'h034, 33'h0_000C_0000);
        rd(12'h038, 33'h1_0000_0000);
        for (int f = 0; f < 4; f++) begin
            apb(1, 12'h030, f);
            rd(12'h030, f);
        end
        repeat (12) begin
            v = xs() & 32'hFFFF_0211;
            apb(1, 12'h034, v);
            rd(12'h034, v[9] ? {pidp(v[29:24]), v[23:0]} : v);
            check({unmuteOnBreak, unmuteOnSync, unmuteOnId}, {3{v[0] & v[4]}} &
                {v[23:22] == 2'b00, v[23:22] == 2'b01, v[23:22] == 2'b10});
        end
        apb(1, 12'h030, 32'h1);
        for (int h = 0; h < 3; h++) begin
            v = (xs() & 32'hFF3F_0000) | (h << 22) | 32'h0000_0100;
            bitCycles <= 4'(xs() % 4 + 1);
            apb(1, 12'h034, v);
            @(posedge headerDone);
            check(headerPlan, {1'b1, h > 0, h == 2, 5'(v[19:16]) + 5'd1,
                3'(v[21:20]) + 3'd1, v[31:24]});
            @(posedge sys_clk);
            rd(12'h034, v & 32'hFFFF_FEFF);
        end
        conclude();
    end
endmodule
